// ---- design/option_pkg.sv ----
// package: option byte layout, decoded configuration and loader state types
package option_pkg;

  // ==========================================================
  // option area location
  localparam logic [13:0] OPTION_BASE = 14'h3FF0;
  localparam logic [13:0] LAST_ADDR = 14'h3FFF;
  localparam logic [3:0] LAST_IDX = 4'hF;

  // ==========================================================
  // byte indices inside the option area
  localparam logic [3:0] IDX_SYS = 4'h0;
  localparam logic [3:0] IDX_P01 = 4'h1;
  localparam logic [3:0] IDX_P23 = 4'h2;
  localparam logic [3:0] IDX_P45 = 4'h3;
  localparam logic [3:0] IDX_P6 = 4'h4;
  localparam logic [3:0] IDX_DEDOUT = 4'h5;
  localparam logic [3:0] IDX_PC = 4'h7;
  localparam logic [3:0] IDX_ARR = 4'h8;

  // ==========================================================
  // bit positions
  localparam int BIT_PORT5_LVL = 7;
  localparam int BIT_SUBOSC = 5;
  localparam int BIT_MAINOSC = 4;
  localparam int BIT_DEDOUT_LVL = 3;
  localparam int BIT_WDT = 0;
  localparam int BIT_BUF = 6;
  localparam int BIT_ZC = 5;

  // ==========================================================
  // data values
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  localparam logic [7:0] PROTECTED_READ = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ==========================================================
  // decoded static configuration
  typedef struct packed {
    logic subosc_enable;          // 1: crystal, 0: subclock_input_port
    logic main_ceramic;           // 1: resonator, 0: external clock
    logic dedicated_reset_high;   // dedicated_output_group reset level
    logic port_five_reset_high;   // port_five_group reset level
    logic watchdog_enable;
    logic [3:0] port_zero_pullup; // pullup_select 1, open_drain_select 0
    logic [3:0] port_one_pullup;
    logic [3:0] port_two_pullup;
    logic [2:0] port_three_pullup;
    logic [3:0] port_four_pullup;
    logic [3:0] port_five_pullup;
    logic [3:0] port_six_pullup;
    logic [3:0] control_port_pullup;
    logic [3:0] dedicated_pulldown; // pulldown_select 1
    logic buffer_enable;
    logic zero_cross_enable;
    logic [4:0] inverter_enable;  // port_four_bit_one .. analog_input_bit_three
  } cfg_type;

  localparam cfg_type CFG_RESET = '0;

  // programmer side activity seen at the chip
  typedef struct packed {
    logic write;
    logic [13:0] addr;
    logic [7:0] data;
    logic blank_check;
  } prog_req_type;

  typedef enum logic [1:0] {
    LD_ISSUE,
    LD_CAPTURE,
    LD_APPLY,
    LD_RUN
  } load_state_type;

  typedef struct packed {
    load_state_type state;
    logic [3:0] idx;
    logic [15:0][7:0] bytes;
    cfg_type cfg;
    logic cpu_hold;
    logic ext_pend;
    logic [7:0] ext_data;
    logic ext_valid;
  } loader_state_type;

  typedef struct packed {
    logic content_seen;
    logic blank_seen;
    logic protect;
  } guard_state_type;

endpackage : option_pkg

// ---- design/security_guard.sv ----
// module: read protection arming from programmer activity
`timescale 1ns/1ps
module security_guard
  import option_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input prog_req_type prog,
  input wire logic security_enable_line,
  output logic protect_active
);

  guard_state_type s_q;
  guard_state_type s_d;
  logic last_write;

  assign last_write = prog.write && (prog.addr == LAST_ADDR);

  // next state of the guard
  always_comb begin
    s_d = s_q;
    // non-blank content written in an ordinary pass
    if (prog.write && !security_enable_line && prog.data != BLANK_BYTE) begin
      s_d.content_seen = 1'b1;
    end
    // blank check inside a secure pass spoils arming
    if (!security_enable_line) begin
      s_d.blank_seen = 1'b0;
    end else if (prog.blank_check) begin
      s_d.blank_seen = 1'b1;
    end
    // secure pass finishing at the last location arms protection
    if (security_enable_line && last_write && s_q.content_seen &&
        !s_q.blank_seen && !prog.blank_check) begin
      s_d.protect = 1'b1;
    end
    if (reset) begin
      s_d = '0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign protect_active = s_q.protect;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_arm_needs_secure_last;
    $rose(protect_active) |->
      $past(security_enable_line) && $past(last_write);
  endproperty
  a_arm_needs_secure_last: assert property (p_arm_needs_secure_last)
    else $error("protection armed outside a secure last write");

  property p_no_arm_when_blank;
    $rose(protect_active) |-> $past(s_q.content_seen);
  endproperty
  a_no_arm_when_blank: assert property (p_no_arm_when_blank)
    else $error("protection armed with all-blank content");

  property p_no_arm_after_blank_check;
    $rose(protect_active) |-> !$past(s_q.blank_seen);
  endproperty
  a_no_arm_after_blank_check: assert property (p_no_arm_after_blank_check)
    else $error("protection armed after a blank check");

  property p_protect_sticky;
    protect_active |=> protect_active;
  endproperty
  a_protect_sticky: assert property (p_protect_sticky)
    else $error("protection dropped while running");

  c_armed: cover property ($rose(protect_active));

endmodule : security_guard

// ---- design/option_byte_config_loader.sv ----
// module: option byte fetch, decode and protected readback
// Function
// - options come from sixteen top bytes
// - first byte bit5 picks sub-oscillator
// - first byte bit4 picks ceramic main clock
// - first byte bit3 sets dedicated output reset
// - first byte bit7 set: port five low
// - first byte bit0 enables the watchdog
// - output type bits: zero drain, one pullup
// - sixth byte low nibble: drain or pulldown
// - ninth byte bits 6,5 buffers, active low
// - ninth byte bits 4..0 inverters, active low
// - readback answers latched after protection arms return zero until a reset clears protection
// - secure second write pass arms protection
// - all-blank first pass never arms protection
// - blank-program-verify second pass never arms
`timescale 1ns/1ps
module option_byte_config_loader
  import option_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  output logic rom_rd,
  output logic [13:0] rom_addr,
  input wire logic [7:0] rom_data,
  input wire logic ext_read,
  input wire logic [13:0] ext_addr,
  output logic [7:0] ext_data,
  output logic ext_valid,
  output logic cpu_hold,
  output cfg_type cfg,
  input prog_req_type prog,
  input wire logic security_enable_line,
  output logic protect_active
);

  // ==========================================================
  // helpers

  // option bits that enable a feature when cleared
  function automatic logic [4:0] active_low(input logic [4:0] bits);
    active_low = ~bits;
  endfunction : active_low

  // decode of option bytes 0 to 5, 7 and 8 of the sixteen
  function automatic cfg_type decode_cfg(input logic [15:0][7:0] b);
    cfg_type c;
    logic [4:0] arr;
    c = CFG_RESET;
    c.subosc_enable = b[IDX_SYS][BIT_SUBOSC];
    c.main_ceramic = b[IDX_SYS][BIT_MAINOSC];
    c.dedicated_reset_high = b[IDX_SYS][BIT_DEDOUT_LVL];
    c.port_five_reset_high = ~b[IDX_SYS][BIT_PORT5_LVL];
    c.watchdog_enable = b[IDX_SYS][BIT_WDT];
    c.port_zero_pullup = b[IDX_P01][3:0];
    c.port_one_pullup = b[IDX_P01][7:4];
    c.port_two_pullup = b[IDX_P23][3:0];
    c.port_three_pullup = b[IDX_P23][6:4];
    c.port_four_pullup = b[IDX_P45][3:0];
    c.port_five_pullup = b[IDX_P45][7:4];
    c.port_six_pullup = b[IDX_P6][3:0];
    c.control_port_pullup = b[IDX_PC][3:0];
    c.dedicated_pulldown = b[IDX_DEDOUT][3:0];
    arr = active_low({3'b000, b[IDX_ARR][BIT_BUF], b[IDX_ARR][BIT_ZC]});
    c.buffer_enable = arr[1];
    c.zero_cross_enable = arr[0];
    c.inverter_enable = active_low(b[IDX_ARR][4:0]);
    decode_cfg = c;
  endfunction : decode_cfg

  // ==========================================================
  // state

  loader_state_type s_q;
  loader_state_type s_d;

  // read protection tracking on the programmer side
  security_guard u_guard (
    .clk(clk),
    .reset(reset),
    .prog(prog),
    .security_enable_line(security_enable_line),
    .protect_active(protect_active)
  );

  // fetch sequencing, decode and readback
  always_comb begin
    s_d = s_q;
    s_d.ext_valid = 1'b0;
    rom_rd = 1'b0;
    rom_addr = OPTION_BASE;
    case (s_q.state)
      LD_ISSUE: begin
        // address only ever within the option area
        rom_rd = 1'b1;
        rom_addr = OPTION_BASE | {10'h000, s_q.idx};
        s_d.state = LD_CAPTURE;
      end
      LD_CAPTURE: begin
        s_d.bytes[s_q.idx] = rom_data;
        if (s_q.idx == LAST_IDX) begin
          s_d.state = LD_APPLY;
        end else begin
          s_d.idx = 4'(s_q.idx + 4'h1);
          s_d.state = LD_ISSUE;
        end
      end
      LD_APPLY: begin
        // settings latch once, in the same cycle the core leaves reset
        s_d.cfg = decode_cfg(s_q.bytes);
        s_d.cpu_hold = 1'b0;
        s_d.state = LD_RUN;
      end
      LD_RUN: begin
        // one outstanding readback; protected data is masked
        if (s_q.ext_pend) begin
          s_d.ext_pend = 1'b0;
          s_d.ext_valid = 1'b1;
          s_d.ext_data = protect_active ? PROTECTED_READ : rom_data;
        end else if (ext_read) begin
          rom_rd = 1'b1;
          rom_addr = ext_addr;
          s_d.ext_pend = 1'b1;
        end
      end
      default: begin
        s_d.state = LD_ISSUE;
      end
    endcase
    if (reset) begin
      s_d.state = LD_ISSUE;
      s_d.idx = 4'h0;
      s_d.bytes = '0;
      s_d.cfg = CFG_RESET;
      s_d.cpu_hold = 1'b1;
      s_d.ext_pend = 1'b0;
      s_d.ext_data = BYTE_RESET;
      s_d.ext_valid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // outputs from the state register
  assign cpu_hold = s_q.cpu_hold;
  assign cfg = s_q.cfg;
  assign ext_data = s_q.ext_data;
  assign ext_valid = s_q.ext_valid;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_load_time;
    $fell(reset) |-> ##32 cpu_hold ##1 !cpu_hold;
  endproperty
  a_load_time: assert property (p_load_time)
    else $error("core released at the wrong cycle");

  property p_cfg_frozen;
    !cpu_hold && $past(!cpu_hold) |-> $stable(cfg);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen)
    else $error("configuration changed while running");

  property p_fetch_in_area;
    rom_rd && cpu_hold |-> rom_addr[13:4] == OPTION_BASE[13:4];
  endproperty
  a_fetch_in_area: assert property (p_fetch_in_area)
    else $error("option fetch outside the option area");

  property p_capture;
    s_q.state == LD_CAPTURE |=> s_q.bytes[$past(s_q.idx)] == $past(rom_data);
  endproperty
  a_capture: assert property (p_capture)
    else $error("option byte not captured");

  property p_clock_select;
    !cpu_hold |-> cfg.subosc_enable == s_q.bytes[IDX_SYS][BIT_SUBOSC] &&
      cfg.main_ceramic == s_q.bytes[IDX_SYS][BIT_MAINOSC];
  endproperty
  a_clock_select: assert property (p_clock_select)
    else $error("clock source decode wrong");

  property p_main_clock;
    $fell(cpu_hold) |-> cfg.main_ceramic == $past(s_q.bytes[IDX_SYS][4], 2);
  endproperty
  a_main_clock: assert property (p_main_clock)
    else $error("main clock decode wrong");

  property p_reset_levels;
    !cpu_hold |-> cfg.dedicated_reset_high == s_q.bytes[IDX_SYS][3] &&
      cfg.port_five_reset_high != s_q.bytes[IDX_SYS][7];
  endproperty
  a_reset_levels: assert property (p_reset_levels)
    else $error("port reset level decode wrong");

  property p_watchdog;
    !cpu_hold |-> cfg.watchdog_enable == s_q.bytes[IDX_SYS][0];
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("watchdog decode wrong");

  property p_output_types;
    !cpu_hold |-> {cfg.port_one_pullup, cfg.port_zero_pullup} ==
      s_q.bytes[IDX_P01] && {cfg.port_five_pullup, cfg.port_four_pullup} ==
      s_q.bytes[IDX_P45] && cfg.port_six_pullup == s_q.bytes[IDX_P6][3:0];
  endproperty
  a_output_types: assert property (p_output_types)
    else $error("output type decode wrong");

  property p_pulldown;
    !cpu_hold |-> cfg.dedicated_pulldown == s_q.bytes[IDX_DEDOUT][3:0];
  endproperty
  a_pulldown: assert property (p_pulldown)
    else $error("dedicated output type decode wrong");

  property p_buffers;
    !cpu_hold |-> cfg.buffer_enable != s_q.bytes[IDX_ARR][6] &&
      cfg.zero_cross_enable != s_q.bytes[IDX_ARR][5];
  endproperty
  a_buffers: assert property (p_buffers)
    else $error("buffer decode wrong");

  // one check per inverter pin
  for (genvar i = 0; i < 5; i++) begin : g_inv
    property p_inverter;
      !cpu_hold |-> cfg.inverter_enable[i] != s_q.bytes[IDX_ARR][i];
    endproperty
    a_inverter: assert property (p_inverter)
      else $error("inverter decode wrong");
  end

  property p_masked_read;
    ext_valid && protect_active && $past(protect_active) |->
      ext_data == PROTECTED_READ;
  endproperty
  a_masked_read: assert property (p_masked_read)
    else $error("protected data read back");

  property p_read_latency;
    ext_read && !cpu_hold && !s_q.ext_pend |=> ##1 ext_valid;
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("readback answer late");

  // configuration stays cleared until the single apply step
  property p_hold_cfg_clear;
    cpu_hold |-> cfg == CFG_RESET;
  endproperty
  a_hold_cfg_clear: assert property (p_hold_cfg_clear)
    else $error("configuration visible before release");

  property p_release_from_apply;
    $fell(cpu_hold) |-> $past(s_q.state) == LD_APPLY;
  endproperty
  a_release_from_apply: assert property (p_release_from_apply)
    else $error("core released outside the apply step");

  property p_fetch_one_cycle;
    rom_rd && cpu_hold |=> !rom_rd;
  endproperty
  a_fetch_one_cycle: assert property (p_fetch_one_cycle)
    else $error("option fetch strobe longer than one cycle");

  // readback answers stand one cycle, data holds between answers
  property p_valid_pulse;
    ext_valid |=> !ext_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("readback answer longer than one cycle");

  property p_data_held;
    !ext_valid |-> $stable(ext_data);
  endproperty
  a_data_held: assert property (p_data_held)
    else $error("readback data changed without an answer");

  // requests are dropped while loading or while one is pending
  property p_refuse_in_load;
    ext_read && cpu_hold |=> !s_q.ext_pend;
  endproperty
  a_refuse_in_load: assert property (p_refuse_in_load)
    else $error("readback accepted during the option load");

  property p_hold_no_answer;
    cpu_hold |-> !ext_valid;
  endproperty
  a_hold_no_answer: assert property (p_hold_no_answer)
    else $error("readback answered during the option load");

  property p_refuse_pending;
    s_q.ext_pend |=> !s_q.ext_pend && ext_valid;
  endproperty
  a_refuse_pending: assert property (p_refuse_pending)
    else $error("second readback accepted while one is pending");

  c_released: cover property ($fell(cpu_hold));
  c_readback: cover property (ext_valid && !protect_active);
  c_masked: cover property (ext_valid && protect_active);
  c_refused: cover property (ext_read && s_q.ext_pend);

endmodule : option_byte_config_loader

// ---- tb/rom_model.sv ----
// partner model: synchronous option memory written by the programmer
`timescale 1ns/1ps
module rom_model
  import option_pkg::*;
(
  input wire logic clk,
  input wire logic rom_rd,
  input wire logic [13:0] rom_addr,
  output logic [7:0] rom_data,
  input prog_req_type prog
);
  logic [7:0] mem [16384];

  initial begin
    foreach (mem[i]) begin
      mem[i] = 8'h00;
    end
  end

  // ==========================================================
  // programmer writes land in the array; reads answer a cycle later
  always @(posedge clk) begin
    if (prog.write) begin
      mem[prog.addr] <= prog.data;
    end
    if (rom_rd) begin
      rom_data <= mem[rom_addr];
    end else begin
      rom_data <= ~rom_data; // released bus never holds the old byte
    end
  end
endmodule : rom_model

// ---- tb/testbench.sv ----
// testbench: option load, decode, readback and read protection
`timescale 1ns/1ps
module testbench
  import option_pkg::*;
  ;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic rom_rd;
  logic [13:0] rom_addr;
  logic [7:0] rom_data;
  logic ext_read = 1'b0;
  logic [13:0] ext_addr = 14'h0000;
  logic [7:0] ext_data;
  logic ext_valid;
  logic cpu_hold;
  logic protect_active;
  cfg_type cfg;
  prog_req_type prog = '0;
  logic security_enable_line = 1'b0;
  int err_count = 0;
  int n_compared = 0;
  // unused bits zero except bit6 of opt_b first byte, ninth byte bit7 one, last seven bytes zero
  logic [7:0] opt_a [16] = '{8'hA9, 8'h5A, 8'h35, 8'hC3, 8'h09, 8'h05,
    8'h00, 8'h0C, 8'hD5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00};
  logic [7:0] opt_b [16] = '{8'h50, 8'hA5, 8'h4A, 8'h3C, 8'h06, 8'h0A,
    8'h00, 8'h03, 8'hAA, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00};

  always #25 clk = ~clk;

  option_byte_config_loader DUT (.clk(clk), .reset(reset), .rom_rd(rom_rd),
    .rom_addr(rom_addr), .rom_data(rom_data), .ext_read(ext_read),
    .ext_addr(ext_addr), .ext_data(ext_data), .ext_valid(ext_valid),
    .cpu_hold(cpu_hold), .cfg(cfg), .prog(prog),
    .security_enable_line(security_enable_line),
    .protect_active(protect_active));

  rom_model rom (.clk(clk), .rom_rd(rom_rd), .rom_addr(rom_addr),
    .rom_data(rom_data), .prog(prog));

  // ==========================================================
  // shared helpers
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  function automatic cfg_type exp_cfg(input logic [7:0] b [16]);
    cfg_type c;
    c = '0;
    c.subosc_enable = b[0][5];
    c.main_ceramic = b[0][4];
    c.dedicated_reset_high = b[0][3];
    c.port_five_reset_high = ~b[0][7];
    c.watchdog_enable = b[0][0];
    c.port_zero_pullup = b[1][3:0];
    c.port_one_pullup = b[1][7:4];
    c.port_two_pullup = b[2][3:0];
    c.port_three_pullup = b[2][6:4];
    c.port_four_pullup = b[3][3:0];
    c.port_five_pullup = b[3][7:4];
    c.port_six_pullup = b[4][3:0];
    c.control_port_pullup = b[7][3:0];
    c.dedicated_pulldown = b[5][3:0];
    c.buffer_enable = ~b[8][6];
    c.zero_cross_enable = ~b[8][5];
    c.inverter_enable = ~b[8][4:0];
    return c;
  endfunction : exp_cfg

  // ==========================================================
  // scenarios
  task automatic load_and_decode(input logic [7:0] b [16]);
    int n;
    int hits;
    foreach (b[i]) begin
      rom.mem[int'(OPTION_BASE) + i] = b[i];
    end
    reset = 1'b1;
    repeat (16) tick;
    check("hold_in_reset", cpu_hold, 1'b1);
    reset = 1'b0;
    ext_read = 1'b1;
    ext_addr = OPTION_BASE;
    n = 0;
    hits = 0;
    while (cpu_hold === 1'b1 && n < 60) begin
      tick;
      n++;
      hits += int'(ext_valid === 1'b1);
      if (n == 4) begin
        ext_read = 1'b0;
      end
    end
    check("hold_cycles", n, 33);
    check("refused_in_load", hits, 0);
    check("protect_after_reset", protect_active, 1'b0);
    check("cfg", cfg, exp_cfg(b));
    rom.mem[int'(OPTION_BASE)] = ~b[0];
    repeat (8) tick;
    check("cfg_static", cfg, exp_cfg(b));
    rom.mem[int'(OPTION_BASE)] = b[0];
  endtask : load_and_decode

  task automatic readback(input logic [13:0] a, input logic [7:0] exp);
    int hits;
    ext_read = 1'b1;
    ext_addr = a;
    tick;
    check("valid_early", ext_valid, 1'b0);
    tick;
    ext_read = 1'b0;
    check("valid", ext_valid, 1'b1);
    check("read_data", ext_data, exp);
    hits = 0;
    repeat (2) begin
      tick;
      hits += int'(ext_valid === 1'b1);
    end
    check("second_request_dropped", hits, 0);
  endtask : readback

  task automatic prog_pass(input int first, input logic [7:0] val);
    for (int a = first; a <= int'(LAST_ADDR); a++) begin
      prog.write = 1'b1;
      prog.addr = a[13:0];
      prog.data = val;
      tick;
      prog.write = 1'b0;
      tick;
    end
    tick;
  endtask : prog_pass

  task automatic protection_passes;
    security_enable_line = 1'b0;
    prog_pass(int'(OPTION_BASE), BLANK_BYTE);
    security_enable_line = 1'b1;
    prog_pass(int'(OPTION_BASE), BLANK_BYTE);
    check("no_arm_blank_data", protect_active, 1'b0);
    security_enable_line = 1'b0;
    prog_pass(int'(OPTION_BASE), 8'h5A);
    security_enable_line = 1'b1;
    prog.blank_check = 1'b1;
    tick;
    prog.blank_check = 1'b0;
    prog_pass(int'(OPTION_BASE), 8'h5A);
    check("no_arm_blank_check", protect_active, 1'b0);
    security_enable_line = 1'b0;
    tick;
    security_enable_line = 1'b1;
    prog_pass(0, 8'h5A);
    check("armed", protect_active, 1'b1);
    security_enable_line = 1'b0;
    repeat (4) tick;
    check("armed_holds", protect_active, 1'b1);
    readback(14'h3FF1, PROTECTED_READ);
  endtask : protection_passes

  // ==========================================================
  // main sequence and watchdog
  initial begin
    load_and_decode(opt_a);
    readback(14'h3FF1, opt_a[1]);
    protection_passes;
    load_and_decode(opt_b);
    readback(14'h3FF3, opt_b[3]);
    complete_run;
  end

  initial begin
    #(50 * 60000);
    err_count++;
    complete_run;
  end
endmodule : testbench
